// [hw/async_serial_data_path.sv]
// Two-channel asynchronous serial transmit and receive data path
//
// What this block does
// - After a character, next waiting holding byte loads and starts at once.
// - With nothing to send, the transmit pin stays high.
// - Holding byte moves to shifter once empty; writes allowed while shifting.
// - Holding register reads back its contents without disturbing transmission.
// - Holding registers sit at I/O 06h and 07h.
// - Receive bits shift in; whole character moves to buffer when room.
// - Untransferred character when next completes raises overrun.
// - Four-deep receive store per channel; a read returns the oldest.
// - Receive registers are read-only at 08h and 09h.
// - Receiver keeps shifting a new character while the store is full.
// - Shift registers have no software address.
// - Full flag set on load into empty store, errors or not.
// - Three-bit format: data length, parity enable, stop count; start bit.
// - Disabling transmit aborts the character; empty flag keeps its value.
`timescale 1ns/10ps
`default_nettype none
module async_serial_data_path #(
    parameter int  NUM_CH     = asd_pkg::NUM_CH,
    parameter int  RX_DEPTH   = asd_pkg::RX_DEPTH,
    parameter bit  PARITY_ODD = 1'b0
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [7:0]        io_addr,
    input  wire logic [7:0]        io_wdata,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    output logic      [7:0]        io_rdata,
    input  wire logic [NUM_CH-1:0] bit_tick,
    input  wire logic [NUM_CH-1:0] serial_in_pin,
    output logic      [NUM_CH-1:0] serial_out_pin,
    input  wire logic [NUM_CH-1:0] tx_enable_bit,
    input  wire logic [NUM_CH-1:0] fmt_data_len,
    input  wire logic [NUM_CH-1:0] fmt_parity_on,
    input  wire logic [NUM_CH-1:0] fmt_stop_len,
    input  wire logic [NUM_CH-1:0] overrun_clr,
    output logic      [NUM_CH-1:0] tx_empty_flag,
    output logic      [NUM_CH-1:0] rx_full_flag,
    output logic      [NUM_CH-1:0] overrun_flag
);
    // Address hit for a channel from its base; used for every register
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] base,
                                      input int         ch);
        addr_hit = (addr == (base + 8'(ch)));
    endfunction : addr_hit

    logic [7:0] rd_mux [NUM_CH];
    logic [NUM_CH-1:0] rd_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [7:0]               tx_hold;
            logic                     tx_full;
            logic [11:0]              tx_shifter;
            logic [3:0]               tx_left;
            logic                     tx_busy;
            logic                     tx_load;
            logic                     tx_last;
            logic [11:0]              next_frame;
            logic [3:0]               next_len;
            logic                     wr_tx;
            logic                     rd_tx;
            logic                     rd_rx;
            asd_pkg::asd_rx_state_t   rx_state;
            logic [7:0]               rx_work;
            logic [3:0]               rx_cnt;
            logic [7:0]               rx_shifter;
            logic                     rx_held;
            logic                     rx_done;
            logic [7:0]               rx_char;
            logic                     tick;

            asd_fifo_if #(.WIDTH(asd_pkg::DATA_W)) fif ();

            asd_rx_fifo #(
                .WIDTH (asd_pkg::DATA_W),
                .DEPTH (RX_DEPTH)
            ) u_fifo (
                .mclk  (mclk),
                .rst_n (rst_n),
                .fif   (fif)
            );

            // Decode; only holding and receive-out registers exist
            assign wr_tx = io_wr && addr_hit(io_addr,
                                             asd_pkg::ADDR_TX_HOLD0, g);
            assign rd_tx = io_rd && addr_hit(io_addr,
                                             asd_pkg::ADDR_TX_HOLD0, g);
            assign rd_rx = io_rd && addr_hit(io_addr,
                                             asd_pkg::ADDR_RX_OUT0, g);
            assign rd_hit[g] = rd_tx || rd_rx;
            assign rd_mux[g] = rd_tx ? tx_hold : fif.head;
            assign tick = bit_tick[g];

            // Build the outgoing frame, LSB first, padded with stop level
            always_comb
            begin
                logic [7:0] d;
                logic       par;
                int         n;
                d = 8'h00;
                par = 1'b0;
                n = 7;
                next_frame = asd_pkg::RST_FRAME;
                n = fmt_data_len[g] ? 8 : 7;
                d = fmt_data_len[g] ? tx_hold : {1'b0, tx_hold[6:0]};
                par = (^d) ^ PARITY_ODD;
                next_frame[0] = asd_pkg::START_LEVEL;
                for (int i = 0; i < 8; i++)
                begin
                    if (i < n)
                        next_frame[i+1] = d[i];
                end
                if (fmt_parity_on[g])
                    next_frame[n+1] = par;
                next_len = 4'(2 + n + (fmt_parity_on[g] ? 1 : 0)
                                    + (fmt_stop_len[g] ? 1 : 0));
            end

            assign tx_last = tx_busy && tick && (tx_left == 4'h1);
            // Load when idle or at the end of the current character
            assign tx_load = clk_en && tx_enable_bit[g] && tx_full
                             && (!tx_busy || tx_last);

            // Holding register: write sets, transfer clears, set wins
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    tx_hold <= asd_pkg::RST_DATA;
                    tx_full <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (wr_tx)
                        tx_hold <= io_wdata;
                    if (wr_tx)
                        tx_full <= 1'b1;
                    else if (tx_load)
                        tx_full <= 1'b0;
                end
            end

            // Transmit shifter; disable aborts, holding byte is kept
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    tx_shifter <= asd_pkg::RST_FRAME;
                    tx_left    <= asd_pkg::RST_COUNT;
                    tx_busy    <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (!tx_enable_bit[g])
                    begin
                        tx_busy    <= 1'b0;
                        tx_shifter <= asd_pkg::RST_FRAME;
                        tx_left    <= asd_pkg::RST_COUNT;
                    end
                    else if (tx_load)
                    begin
                        tx_shifter <= next_frame;
                        tx_left    <= next_len;
                        tx_busy    <= 1'b1;
                    end
                    else if (tx_last)
                        tx_busy    <= 1'b0;
                    else if (tx_busy && tick)
                    begin
                        tx_shifter <= {asd_pkg::LINE_IDLE, tx_shifter[11:1]};
                        tx_left    <= tx_left - 4'h1;
                    end
                end
            end

            // Pin from a flop bit; idle level when nothing shifts
            assign serial_out_pin[g] = tx_busy ? tx_shifter[0]
                                               : asd_pkg::LINE_IDLE;
            // Empty flag only follows the holding register
            assign tx_empty_flag[g] = !tx_full;

            // Receive framing, sampled once per bit tick
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    rx_state <= asd_pkg::ASD_RX_IDLE;
                    rx_work  <= asd_pkg::RST_DATA;
                    rx_cnt   <= asd_pkg::RST_COUNT;
                end
                else if (clk_en && tick)
                begin
                    case (rx_state)
                        asd_pkg::ASD_RX_IDLE:
                        begin
                            rx_cnt <= asd_pkg::RST_COUNT;
                            if (serial_in_pin[g] == asd_pkg::START_LEVEL)
                                rx_state <= asd_pkg::ASD_RX_DATA;
                        end
                        asd_pkg::ASD_RX_DATA:
                        begin
                            rx_work <= {serial_in_pin[g], rx_work[7:1]};
                            rx_cnt  <= rx_cnt + 4'h1;
                            if (rx_cnt == (fmt_data_len[g] ? 4'h7 : 4'h6))
                                rx_state <= fmt_parity_on[g]
                                            ? asd_pkg::ASD_RX_PARITY
                                            : asd_pkg::ASD_RX_STOP;
                        end
                        asd_pkg::ASD_RX_PARITY:
                            rx_state <= asd_pkg::ASD_RX_STOP;
                        asd_pkg::ASD_RX_STOP:
                            rx_state <= asd_pkg::ASD_RX_IDLE;
                        default:
                            rx_state <= asd_pkg::ASD_RX_IDLE;
                    endcase
                end
            end

            // Character complete at stop bit, framing errors not filtered
            assign rx_done = clk_en && tick
                             && (rx_state == asd_pkg::ASD_RX_STOP);
            assign rx_char = fmt_data_len[g] ? rx_work
                                             : {1'b0, rx_work[7:1]};

            assign fif.ce        = clk_en;
            assign fif.push      = rx_held;
            assign fif.push_data = rx_shifter;
            assign fif.pop       = rd_rx;

            // Assembled character waits here until the store has room
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    rx_shifter <= asd_pkg::RST_DATA;
                    rx_held    <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (rx_done && (!rx_held || !fif.full))
                    begin
                        rx_shifter <= rx_char;
                        rx_held    <= 1'b1;
                    end
                    else if (rx_held && !fif.full)
                        rx_held    <= 1'b0;
                end
            end

            // Overrun keeps the older character; set wins over clear
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    overrun_flag[g] <= 1'b0;
                else if (clk_en)
                begin
                    if (rx_done && rx_held && fif.full)
                        overrun_flag[g] <= 1'b1;
                    else if (overrun_clr[g])
                        overrun_flag[g] <= 1'b0;
                end
            end

            assign rx_full_flag[g] = !fif.empty;
        end
    endgenerate

    // Registered read data; unmapped reads return zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            io_rdata <= asd_pkg::RST_DATA;
        else if (clk_en && io_rd)
        begin
            io_rdata <= asd_pkg::RST_DATA;
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (rd_hit[c])
                    io_rdata <= rd_mux[c];
            end
        end
    end
endmodule : async_serial_data_path
`default_nettype wire

// [hw/asd_pkg.sv]
// Constants shared by the asynchronous serial data path
package asd_pkg;
    localparam int          NUM_CH       = 2;
    localparam int          RX_DEPTH     = 4;
    localparam int          DATA_W       = 8;
    localparam int          FRAME_W      = 12;
    // Register byte addresses in I/O space
    localparam logic [7:0]  ADDR_TX_HOLD0 = 8'h06;
    localparam logic [7:0]  ADDR_TX_HOLD1 = 8'h07;
    localparam logic [7:0]  ADDR_RX_OUT0  = 8'h08;
    localparam logic [7:0]  ADDR_RX_OUT1  = 8'h09;
    // Format field bit positions
    localparam int          FMT_DATA_LEN  = 2;
    localparam int          FMT_PARITY_ON = 1;
    localparam int          FMT_STOP_LEN  = 0;
    // Reset values
    localparam logic [7:0]  RST_DATA      = 8'h00;
    localparam logic [11:0] RST_FRAME     = 12'hFFF;
    localparam logic [3:0]  RST_COUNT     = 4'h0;
    localparam logic        LINE_IDLE     = 1'b1;
    localparam logic        START_LEVEL   = 1'b0;
    typedef enum logic [1:0] {
        ASD_RX_IDLE,
        ASD_RX_DATA,
        ASD_RX_PARITY,
        ASD_RX_STOP
    } asd_rx_state_t;
endpackage : asd_pkg

// [hw/asd_fifo_if.sv]
// Push and pop signals between a channel and its receive store
`timescale 1ns/10ps
`default_nettype none
interface asd_fifo_if #(parameter int WIDTH = 8);
    logic             ce;
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             full;
    logic             pop;
    logic [WIDTH-1:0] head;
    logic             empty;
    modport store (input ce, push, push_data, pop,
                   output full, head, empty);
    modport user  (output ce, push, push_data, pop,
                   input full, head, empty);
endinterface : asd_fifo_if
`default_nettype wire

// [hw/asd_rx_fifo.sv]
// First-in first-out store for received characters
`timescale 1ns/10ps
`default_nettype none
module asd_rx_fifo #(
    parameter int WIDTH = asd_pkg::DATA_W,
    parameter int DEPTH = asd_pkg::RX_DEPTH
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    asd_fifo_if.store  fif
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_push;
    logic             do_pop;

    // Refused push or pop simply does nothing
    assign do_push   = fif.ce && fif.push && !fif.full;
    assign do_pop    = fif.ce && fif.pop && !fif.empty;
    assign fif.full  = (count == (AW+1)'(DEPTH));
    assign fif.empty = (count == '0);
    assign fif.head  = mem[rd_ptr];  // Oldest character

    // Storage array, no reset needed for data
    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem[wr_ptr] <= fif.push_data;
    end

    // Pointers wrap at depth
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
    end

    // Occupancy count
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (do_push && !do_pop)
            count <= count + 1'b1;
        else if (do_pop && !do_push)
            count <= count - 1'b1;
    end
endmodule : asd_rx_fifo
`default_nettype wire

// [verification/asd_asserts.sv]
// Port-level checks for the serial data path
`timescale 1ns/10ps
`default_nettype none
module asd_asserts #(
    parameter int NUM_CH = 2
) (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic [7:0]        io_addr,
    input wire logic              io_wr,
    input wire logic              io_rd,
    input wire logic [7:0]        io_rdata,
    input wire logic [NUM_CH-1:0] serial_out_pin,
    input wire logic [NUM_CH-1:0] tx_enable_bit,
    input wire logic [NUM_CH-1:0] overrun_clr,
    input wire logic [NUM_CH-1:0] tx_empty_flag,
    input wire logic [NUM_CH-1:0] rx_full_flag,
    input wire logic [NUM_CH-1:0] overrun_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_wr_busy;
        clk_en && io_wr && io_addr == asd_pkg::ADDR_TX_HOLD0
            |=> !tx_empty_flag[0];
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("holding not full");
    property p_unmapped;
        clk_en && io_rd && (io_addr < asd_pkg::ADDR_TX_HOLD0
            || io_addr > asd_pkg::ADDR_RX_OUT1) |=> io_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_rdata_stands;
        !(clk_en && io_rd) |=> $stable(io_rdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("rdata moved");
    property p_off_idle;
        !tx_enable_bit[1] [*2] |-> serial_out_pin[1];
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("line not idle");
    property p_empty_kept;
        !tx_enable_bit[1] && !(clk_en && io_wr) |=> $stable(tx_empty_flag[1]);
    endproperty
    a_empty_kept: assert property (p_empty_kept) else $error("empty moved");
    property p_full_kept;
        rx_full_flag[0] && !(io_rd && io_addr == asd_pkg::ADDR_RX_OUT0)
            |=> rx_full_flag[0];
    endproperty
    a_full_kept: assert property (p_full_kept) else $error("full dropped");
    property p_ovr_sticky;
        overrun_flag[0] && !overrun_clr[0] |=> overrun_flag[0];
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");
    property p_ovr_cause;
        $rose(overrun_flag[0]) |-> $past(rx_full_flag[0], 1);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("overrun early");
    property p_rx_ro;
        clk_en && io_wr && io_addr == asd_pkg::ADDR_RX_OUT0 && !rx_full_flag[0]
            |=> !rx_full_flag[0];
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("write filled store");
endmodule : asd_asserts
bind async_serial_data_path asd_asserts #(.NUM_CH(NUM_CH)) u_asserts (
    .mclk, .rst_n, .clk_en, .io_addr, .io_wr, .io_rd, .io_rdata,
    .serial_out_pin, .tx_enable_bit, .overrun_clr, .tx_empty_flag,
    .rx_full_flag, .overrun_flag);
`default_nettype wire

// [verification/asd_line_model.sv]
// Remote serial device on one channel's pair of lines
`timescale 1ns/10ps
`default_nettype none
module asd_line_model (
    input  wire logic       mclk,
    input  wire logic       tick,
    input  wire logic [2:0] fmt,
    input  wire logic       from_dut,
    output logic            to_dut
);
    logic [8:0] got[$];
    logic [7:0] sh = 8'h00;
    logic       pe = 1'b0;
    int         st = 0;
    int         nd;
    assign nd = fmt[2] ? 8 : 7;
    initial to_dut = 1'b1;
    // One frame, a bit per tick; bad flips parity on purpose
    task automatic send(input logic [7:0] d, input logic bad);
        logic [11:0] f;
        int          i;
        f = 12'hFFF;
        f[0] = 1'b0;
        for (i = 0; i < nd; i++)
            f[i+1] = d[i];
        if (fmt[1])
            f[nd+1] = ^(d & (fmt[2] ? 8'hFF : 8'h7F)) ^ bad;
        for (i = 0; i < nd + 2 + fmt[1] + fmt[0]; i++)
        begin
            @(posedge mclk iff tick);
            to_dut <= f[i];
        end
    endtask : send
    // Frame catcher; second stop just reads as idle
    always @(posedge mclk)
    begin
        if (tick && st == 0 && from_dut === 1'b0)
        begin
            st = 1;
            sh = 8'h00;
        end
        else if (tick && st > 0 && st <= nd)
        begin
            sh[st-1] = from_dut;
            st++;
        end
        else if (tick && st == nd + 1 && fmt[1])
        begin
            pe = from_dut ^ (^sh);
            st++;
        end
        else if (tick && st > 0)
        begin
            got.push_back({(fmt[1] & pe) | !from_dut, sh});
            st = 0;
        end
    end
endmodule : asd_line_model
`default_nettype wire

// [verification/async_serial_data_path_test.sv]
// Self-checking bench for the serial data path
`timescale 1ns/10ps
`default_nettype none
module async_serial_data_path_test;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic       clk_en = 1'b1;
    logic [7:0] io_rdata;
    logic [1:0] bit_tick = 2'h0;
    wire  logic [1:0] serial_in_pin;
    logic [1:0] serial_out_pin;
    logic [1:0] tx_enable_bit = 2'h1;
    logic [2:0] fmt0 = 3'h7;
    logic [2:0] fmt1 = 3'h4;
    logic [1:0] overrun_clr = 2'h0;
    logic [1:0] tx_empty_flag;
    logic [1:0] rx_full_flag;
    logic [1:0] overrun_flag;
    logic [8:0] exp_rd[$];
    logic [8:0] exp_l0[$];
    logic [8:0] exp_l1[$];
    logic       rd_q = 1'b0;
    logic [1:0] tcnt = 2'h0;
    int         n_fail = 0;
    int         checks = 0;
    int         seed = 70156;
    async_serial_data_path uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .bit_tick(bit_tick),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .tx_enable_bit(tx_enable_bit), .fmt_data_len({fmt1[2], fmt0[2]}),
        .fmt_parity_on({fmt1[1], fmt0[1]}), .fmt_stop_len({fmt1[0], fmt0[0]}),
        .overrun_clr(overrun_clr), .tx_empty_flag(tx_empty_flag),
        .rx_full_flag(rx_full_flag), .overrun_flag(overrun_flag));
    asd_line_model m0 (.mclk(mclk), .tick(bit_tick[0]), .fmt(fmt0),
        .from_dut(serial_out_pin[0]), .to_dut(serial_in_pin[0]));
    asd_line_model m1 (.mclk(mclk), .tick(bit_tick[1]), .fmt(fmt1),
        .from_dut(serial_out_pin[1]), .to_dut(serial_in_pin[1]));
    always #25 mclk = ~mclk;
    // Bit strobes every four clocks; short frames keep the run brief
    always @(posedge mclk)
    begin
        tcnt     <= tcnt + 2'h1;
        bit_tick <= (tcnt == 2'h3) ? 2'h3 : 2'h0;
        rd_q     <= io_rd;
    end
    // Oldest note against each result as it shows
    always @(posedge mclk)
    begin
        if (rd_q)
            chk_val({1'b0, io_rdata}, exp_rd.pop_front());
        if (m0.got.size() > 0)
            chk_val(m0.got.pop_front(), exp_l0.pop_front());
        if (m1.got.size() > 0)
            chk_val(m1.got.pop_front(), exp_l1.pop_front());
    end
    task automatic chk_val(input logic [8:0] g, input logic [8:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_bit(input logic [1:0] g, input logic [1:0] e);
        chk_val({7'h00, g}, {7'h00, e});
    endtask : chk_bit
    task automatic bus(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= w;
        io_rd    <= !w;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back({1'b0, e});
        bus(a, 8'h00, 1'b0);
    endtask : rd
    // Bounded wait on the full or overrun flag of one channel
    task automatic wait_flag(input int ch, input bit ovr);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(posedge mclk);
            if ((ovr ? overrun_flag[ch] : rx_full_flag[ch]) === 1'b1)
                break;
        end
        if (i == 400)
        begin
            n_fail++;
            results();
        end
    endtask : wait_flag
    // Let every noted result arrive, then two quiet bit times
    task automatic drain;
        int i;
        for (i = 0; i < 2000 && exp_rd.size() + exp_l0.size()
             + exp_l1.size() > 0; i++)
            @(posedge mclk);
        if (i == 2000)
        begin
            n_fail++;
            results();
        end
        repeat (2) @(posedge mclk iff bit_tick[0]);
    endtask : drain
    task results;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial
    begin : main
        logic [7:0] d;
        logic [7:0] c[6];
        logic [7:0] ua[3];
        int         f;
        ua = '{8'h05, 8'h0A, 8'hFF};
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk_bit(serial_out_pin, 2'h3);
        chk_bit(tx_empty_flag, 2'h3);
        chk_bit({rx_full_flag[0], overrun_flag[0]}, 2'h0);
        // Second write lands while the first byte shifts out
        d = 8'($random(seed));
        exp_l0.push_back({1'b0, d});
        exp_l0.push_back({1'b0, ~d});
        bus(asd_pkg::ADDR_TX_HOLD0, d, 1'b1);
        bus(asd_pkg::ADDR_TX_HOLD0, ~d, 1'b1);
        rd(asd_pkg::ADDR_TX_HOLD0, ~d);
        d = 8'($random(seed));
        bus(asd_pkg::ADDR_TX_HOLD1, d, 1'b1);
        rd(asd_pkg::ADDR_TX_HOLD1, d);
        foreach (ua[i])
            rd(ua[i], 8'h00);
        // Disabled channel keeps its line high and its byte waiting
        repeat (40) @(posedge mclk);
        #1 chk_bit({serial_out_pin[1], tx_empty_flag[1]}, 2'h2);
        exp_l1.push_back({1'b0, d});
        @(posedge mclk);
        tx_enable_bit <= 2'h3;
        // Every format both ways
        for (f = 0; f < 8; f++)
        begin
            drain();
            fmt0 <= f[2:0];
            fmt1 <= f[2:0];
            d = 8'($random(seed));
            exp_l0.push_back({1'b0, f[2] ? d : {1'b0, d[6:0]}});
            bus(asd_pkg::ADDR_TX_HOLD0, d, 1'b1);
            m1.send(~d, 1'b0);
            wait_flag(1, 1'b0);
            rd(asd_pkg::ADDR_RX_OUT1, f[2] ? ~d : {1'b0, ~d[6:0]});
        end
        // Fill the store, park one, lose one; one has bad parity
        bus(asd_pkg::ADDR_RX_OUT0, 8'hA5, 1'b1);
        for (f = 0; f < 6; f++)
        begin
            c[f] = 8'($random(seed));
            m0.send(c[f], f == 1);
        end
        wait_flag(0, 1'b1);
        #1 chk_bit({rx_full_flag[0], overrun_flag[0]}, 2'h3);
        for (f = 0; f < 5; f++)
            rd(asd_pkg::ADDR_RX_OUT0, c[f]);
        @(posedge mclk);
        overrun_clr <= 2'h1;
        @(posedge mclk);
        overrun_clr <= 2'h0;
        drain();
        #1 chk_bit({rx_full_flag[0], overrun_flag[0]}, 2'h0);
        chk_bit(serial_out_pin, 2'h3);
        // Abort mid-data; rest of the frame reads as idle ones, bad parity
        bus(asd_pkg::ADDR_TX_HOLD0, 8'hFF, 1'b1);
        exp_l0.push_back(9'h1FF);
        repeat (8) @(posedge mclk);
        tx_enable_bit <= 2'h2;
        drain();
        #1 chk_bit(tx_empty_flag, 2'h3);
        // Frozen block must ignore a write
        @(posedge mclk);
        clk_en <= 1'b0;
        bus(asd_pkg::ADDR_TX_HOLD1, 8'h3C, 1'b1);
        #1 chk_bit(tx_empty_flag, 2'h3);
        results();
    end
endmodule : async_serial_data_path_test
`default_nettype wire
